// [core/dmtra_cfg.svh]
// dmtra_cfg.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from dmtra_top only
`ifndef DMTRA_CFG_SVH
`define DMTRA_CFG_SVH

// special function register offsets in data memory
`define DMTRA_OFF_WIN_A     8'h00
`define DMTRA_OFF_PTR_A     8'h01
`define DMTRA_OFF_WIN_B     8'h02
`define DMTRA_OFF_PTR_B     8'h03
`define DMTRA_OFF_BANK      8'h04
`define DMTRA_OFF_TBLP      8'h07
`define DMTRA_OFF_TABLE_HIGH_BYTE      8'h08

// general purpose area: offsets 80h..ffh of every bank
`define DMTRA_GP_BASE       8'h80

// writable bits of bank_select for each memory variant
`define DMTRA_BS_MASK_LARGE 8'h67
`define DMTRA_BS_MASK_SMALL 8'h23

// bank_select field positions
`define DMTRA_PMB_HI        6
`define DMTRA_PMB_LO        5
`define DMTRA_DMB_MSB       2

// reset values
`define DMTRA_BS_RST        8'h00
`define DMTRA_PTR_RST       8'h00
`define DMTRA_TBLP_RST      8'h00
`define DMTRA_TABLE_HIGH_BYTE_RST      8'h00

// forced upper table address on a last-page read
`define DMTRA_LAST_PAGE     7'h7f

// clocks from taking a table read to its done pulse
`define DMTRA_TBL_CYCLES    2

`endif

// [core/dmtra_pkg.sv]
// dmtra_pkg: types shared by the data memory / table read addressing block
// assumes: dmtra_cfg.svh holds all numeric constants
package dmtra_pkg;

  // operations the execution core may request
  typedef enum logic [2:0] {
    DMTRA_OP_READ   = 3'h0,
    DMTRA_OP_WRITE  = 3'h1,
    DMTRA_OP_BSET   = 3'h2,
    DMTRA_OP_BCLR   = 3'h3,
    DMTRA_OP_TABRDC = 3'h4,
    DMTRA_OP_TABRDL = 3'h5
  } dmtra_op_t;

  // what a resolved data memory address lands on
  typedef enum logic [1:0] {
    DMTRA_TGT_NONE = 2'h0,
    DMTRA_TGT_SFR  = 2'h1,
    DMTRA_TGT_RAM  = 2'h2
  } dmtra_kind_t;

  typedef enum logic [0:0] {
    DMTRA_ST_IDLE = 1'b0,
    DMTRA_ST_WAIT = 1'b1
  } dmtra_st_t;

  // request from the execution core
  typedef struct packed {
    logic       valid;
    dmtra_op_t  op;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] bit_idx;
  } dmtra_req_t;

  typedef struct packed {
    dmtra_kind_t kind;
    logic [7:0]  sfr;
    logic [9:0]  ram;
  } dmtra_tgt_t;

  // whole state of the top module
  typedef struct packed {
    dmtra_st_t   st;
    logic [7:0]  ptr_a;
    logic [7:0]  ptr_b;
    logic [7:0]  bank_sel;
    logic [7:0]  tblp;
    logic [7:0]  table_high_byte;
    dmtra_op_t   pend_op;
    dmtra_tgt_t  pend_tgt;
    logic [2:0]  pend_bit;
    logic [14:0] pm_addr;
    logic        pm_rd;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        busy;
    logic        done;
  } dmtra_state_t;

  typedef struct packed {
    logic [7:0] rdata;
  } dmtra_ram_state_t;

endpackage

// [core/dmtra_ram.sv]
// dmtra_ram: general purpose data memory, 8 banks of 128 bytes
// assumes: one clock, write and registered read in the same cycle
`timescale 1ns/1ns
`default_nettype none
module dmtra_ram (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       we,
  input  wire logic [9:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [9:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0]                 mem [0:1023];
  dmtra_pkg::dmtra_ram_state_t s_r;
  dmtra_pkg::dmtra_ram_state_t s_nxt;

  // read data always leave through a register
  always_comb begin
    s_nxt.rdata = mem[raddr];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // memory contents are not reset
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = s_r.rdata;
endmodule // dmtra_ram
`default_nettype wire

// [core/dmtra_top.sv]
// dmtra_top: data memory addressing and table read address generation
// assumes: driven by the execution core on ref_clk; program memory answers
//          pm_rdata combinationally in the cycle pm_rd is high
`timescale 1ns/1ns
`default_nettype none
`include "dmtra_cfg.svh"
module dmtra_top #(
  parameter bit LARGE_MEM = 1'b1
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire dmtra_pkg::dmtra_req_t req,
  input  wire logic [6:0]            program_counter_upper_bits,
  input  wire logic [15:0]           pm_rdata,
  output logic      [14:0]           pm_addr,
  output logic                       pm_rd,
  output logic      [7:0]            rd_data,
  output logic                       rd_valid,
  output logic                       busy,
  output logic                       done
);
  dmtra_pkg::dmtra_state_t s_r;
  dmtra_pkg::dmtra_state_t s_nxt;
  dmtra_pkg::dmtra_tgt_t   tgt;
  logic                    take;
  logic                    ram_we;
  logic [9:0]              ram_waddr;
  logic [7:0]              ram_wdata;
  logic [7:0]              ram_rdata;
  logic [7:0]              old_val;
  logic [7:0]              new_val;

  localparam logic [7:0] BS_MASK = LARGE_MEM ? `DMTRA_BS_MASK_LARGE : `DMTRA_BS_MASK_SMALL;

  // special registers that really exist as storage
  function automatic logic is_impl(input logic [7:0] a);
    is_impl = (a == `DMTRA_OFF_PTR_A) || (a == `DMTRA_OFF_PTR_B) ||
              (a == `DMTRA_OFF_BANK) || (a == `DMTRA_OFF_TBLP) ||
              (a == `DMTRA_OFF_TABLE_HIGH_BYTE);
  endfunction

  // map a direct operand address onto its final target
  function automatic dmtra_pkg::dmtra_tgt_t resolve(input logic [7:0] a,
                                                    input logic [7:0] pa,
                                                    input logic [7:0] pb,
                                                    input logic [7:0] bs);
    dmtra_pkg::dmtra_tgt_t t;
    logic [7:0]            ea;
    logic [2:0]            bk;
    logic                  ind;
    ea  = a;
    bk  = 3'h0;
    ind = 1'b0;
    if (a == `DMTRA_OFF_WIN_A) begin
      ea  = pa;
      bk  = 3'h0;
      ind = 1'b1;
    end else if (a == `DMTRA_OFF_WIN_B) begin
      ea  = pb;
      bk  = bs[`DMTRA_DMB_MSB:0];
      ind = 1'b1;
    end
    t.sfr  = ea;
    t.ram  = {bk, ea[6:0]};
    if (ea >= `DMTRA_GP_BASE) begin
      t.kind = dmtra_pkg::DMTRA_TGT_RAM;
    end else if (ind && (ea == `DMTRA_OFF_WIN_A || ea == `DMTRA_OFF_WIN_B)) begin
      t.kind = dmtra_pkg::DMTRA_TGT_NONE;
    end else if (is_impl(ea)) begin
      t.kind = dmtra_pkg::DMTRA_TGT_SFR;
    end else begin
      t.kind = dmtra_pkg::DMTRA_TGT_NONE;
    end
    return t;
  endfunction

  // special register read mux; unused locations give zero
  function automatic logic [7:0] sfr_rd(input dmtra_pkg::dmtra_state_t s,
                                        input logic [7:0] a);
    case (a)
      `DMTRA_OFF_PTR_A: sfr_rd = s.ptr_a;
      `DMTRA_OFF_PTR_B: sfr_rd = s.ptr_b;
      `DMTRA_OFF_BANK:  sfr_rd = s.bank_sel;
      `DMTRA_OFF_TBLP:  sfr_rd = s.tblp;
      `DMTRA_OFF_TABLE_HIGH_BYTE:  sfr_rd = s.table_high_byte;
      default:          sfr_rd = 8'h00;
    endcase
  endfunction

  // special register write; table_high_byte takes no software write
  function automatic dmtra_pkg::dmtra_state_t sfr_wr(input dmtra_pkg::dmtra_state_t s,
                                                     input logic [7:0] a,
                                                     input logic [7:0] d);
    dmtra_pkg::dmtra_state_t r;
    r = s;
    case (a)
      `DMTRA_OFF_PTR_A: r.ptr_a    = d;
      `DMTRA_OFF_PTR_B: r.ptr_b    = d;
      `DMTRA_OFF_BANK:  r.bank_sel = d & BS_MASK;        // unimplemented bits stay zero
      `DMTRA_OFF_TBLP:  r.tblp     = d;
      default:          r          = s;
    endcase
    return r;
  endfunction

  // table address: low byte from the pointer, upper bits by page form
  function automatic logic [14:0] tbl_addr(input logic last,
                                           input logic [7:0] tp,
                                           input logic [7:0] bs,
                                           input logic [6:0] pc);
    logic [6:0] up;
    if (last) begin
      up = `DMTRA_LAST_PAGE;
    end else begin
      up = {bs[`DMTRA_PMB_HI], bs[`DMTRA_PMB_LO], pc[4:0]};
    end
    if (!LARGE_MEM) begin
      up[6] = 1'b0;
    end
    tbl_addr = {up, tp};
  endfunction

  assign take    = req.valid && (s_r.st == dmtra_pkg::DMTRA_ST_IDLE);
  assign tgt     = resolve(req.addr, s_r.ptr_a, s_r.ptr_b, s_r.bank_sel);
  assign old_val = (s_r.pend_tgt.kind == dmtra_pkg::DMTRA_TGT_RAM) ? ram_rdata :
                   (s_r.pend_tgt.kind == dmtra_pkg::DMTRA_TGT_SFR) ?
                   sfr_rd(s_r, s_r.pend_tgt.sfr) : 8'h00;

  // next state: take a request in idle, finish a write there and any other operation in the wait cycle
  always_comb begin
    s_nxt     = s_r;
    s_nxt.done     = 1'b0;
    s_nxt.rd_valid = 1'b0;
    ram_we    = 1'b0;
    ram_waddr = s_r.pend_tgt.ram;
    ram_wdata = 8'h00;
    new_val   = old_val;
    case (s_r.st)
      dmtra_pkg::DMTRA_ST_IDLE: begin
        if (take) begin
          s_nxt.pend_op  = req.op;
          s_nxt.pend_tgt = tgt;
          s_nxt.pend_bit = req.bit_idx;
          if (req.op == dmtra_pkg::DMTRA_OP_WRITE) begin
            s_nxt.done = 1'b1;
            if (tgt.kind == dmtra_pkg::DMTRA_TGT_RAM) begin
              ram_we    = 1'b1;
              ram_waddr = tgt.ram;
              ram_wdata = req.wdata;
            end else if (tgt.kind == dmtra_pkg::DMTRA_TGT_SFR) begin
              s_nxt = sfr_wr(s_nxt, tgt.sfr, req.wdata);
            end
          end else begin
            s_nxt.st   = dmtra_pkg::DMTRA_ST_WAIT;
            s_nxt.busy = 1'b1;
            if (req.op == dmtra_pkg::DMTRA_OP_TABRDC || req.op == dmtra_pkg::DMTRA_OP_TABRDL) begin
              s_nxt.pm_rd   = 1'b1;
              s_nxt.pm_addr = tbl_addr(req.op == dmtra_pkg::DMTRA_OP_TABRDL, s_r.tblp,
                                       s_r.bank_sel, program_counter_upper_bits);
            end
          end
        end
      end
      dmtra_pkg::DMTRA_ST_WAIT: begin
        s_nxt.st    = dmtra_pkg::DMTRA_ST_IDLE;
        s_nxt.busy  = 1'b0;
        s_nxt.pm_rd = 1'b0;
        s_nxt.done  = 1'b1;
        case (s_r.pend_op)
          dmtra_pkg::DMTRA_OP_READ: begin
            s_nxt.rd_data  = old_val;
            s_nxt.rd_valid = 1'b1;
          end
          dmtra_pkg::DMTRA_OP_BSET: new_val = old_val | (8'h01 << s_r.pend_bit);
          dmtra_pkg::DMTRA_OP_BCLR: new_val = old_val & ~(8'h01 << s_r.pend_bit);
          dmtra_pkg::DMTRA_OP_TABRDC,
          dmtra_pkg::DMTRA_OP_TABRDL: begin
            new_val    = pm_rdata[7:0];
            s_nxt.table_high_byte = pm_rdata[15:8];
          end
          default: new_val = old_val;
        endcase
        if (s_r.pend_op != dmtra_pkg::DMTRA_OP_READ) begin
          if (s_r.pend_tgt.kind == dmtra_pkg::DMTRA_TGT_RAM) begin
            ram_we    = 1'b1;
            ram_wdata = new_val;
          end else if (s_r.pend_tgt.kind == dmtra_pkg::DMTRA_TGT_SFR) begin
            s_nxt = sfr_wr(s_nxt, s_r.pend_tgt.sfr, new_val);
          end
        end
      end
      default: s_nxt.st = dmtra_pkg::DMTRA_ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r          <= '0;
      s_r.ptr_a    <= `DMTRA_PTR_RST;
      s_r.ptr_b    <= `DMTRA_PTR_RST;
      s_r.bank_sel <= `DMTRA_BS_RST;
      s_r.tblp     <= `DMTRA_TBLP_RST;
      s_r.table_high_byte     <= `DMTRA_TABLE_HIGH_BYTE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // general purpose memory, 8 bits wide
  dmtra_ram u_ram (
    .ref_clk (ref_clk),
    .rst     (rst),
    .we      (ram_we),
    .waddr   (ram_waddr),
    .wdata   (ram_wdata),
    .raddr   (tgt.ram),
    .rdata   (ram_rdata)
  );

  // outputs straight from the state register
  assign pm_addr  = s_r.pm_addr;
  assign pm_rd    = s_r.pm_rd;
  assign rd_data  = s_r.rd_data;
  assign rd_valid = s_r.rd_valid;
  assign busy     = s_r.busy;
  assign done     = s_r.done;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic tab_take;
  assign tab_take = take && (req.op == dmtra_pkg::DMTRA_OP_TABRDC ||
                             req.op == dmtra_pkg::DMTRA_OP_TABRDL);

  // a write lands at the taking edge, a bit op one edge later: watch both
  property p_table_high_byte_ro;
    take && req.addr == `DMTRA_OFF_TABLE_HIGH_BYTE && req.op != dmtra_pkg::DMTRA_OP_READ &&
    req.op != dmtra_pkg::DMTRA_OP_TABRDC && req.op != dmtra_pkg::DMTRA_OP_TABRDL
    |=> $stable(s_r.table_high_byte) [*2];
  endproperty
  a_table_high_byte_ro: assert property (p_table_high_byte_ro) else $error("table_high_byte changed by write");

  property p_tbl_two;
    tab_take |=> busy && pm_rd ##1 done && !busy && !pm_rd;
  endproperty
  a_tbl_two: assert property (p_tbl_two) else $error("table read not two cycles");

  property p_last_page;
    take && req.op == dmtra_pkg::DMTRA_OP_TABRDL
    |=> pm_addr[7:0] == $past(s_r.tblp) && pm_addr[13:8] == 6'h3f;
  endproperty
  a_last_page: assert property (p_last_page) else $error("last page address wrong");

  property p_cur_page;
    take && req.op == dmtra_pkg::DMTRA_OP_TABRDC
    |=> pm_addr[12:8] == $past(program_counter_upper_bits[4:0]) &&
        pm_addr[13] == $past(s_r.bank_sel[`DMTRA_PMB_LO]);
  endproperty
  a_cur_page: assert property (p_cur_page) else $error("current page address wrong");

  property p_width;
    pm_rd |-> (LARGE_MEM ? pm_addr[14] == $past(s_r.bank_sel[`DMTRA_PMB_HI]) ||
               $past(req.op) == dmtra_pkg::DMTRA_OP_TABRDL : !pm_addr[14]);
  endproperty
  a_width: assert property (p_width) else $error("table address width wrong");

  property p_unused_zero;
    take && req.op == dmtra_pkg::DMTRA_OP_READ && req.addr < `DMTRA_GP_BASE &&
    !is_impl(req.addr) && req.addr != `DMTRA_OFF_WIN_A && req.addr != `DMTRA_OFF_WIN_B
    |-> ##2 rd_valid && rd_data == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused location not zero");

  property p_win_self;
    take && req.op == dmtra_pkg::DMTRA_OP_READ && req.addr == `DMTRA_OFF_WIN_A &&
    (s_r.ptr_a == `DMTRA_OFF_WIN_A || s_r.ptr_a == `DMTRA_OFF_WIN_B)
    |-> ##2 rd_data == 8'h00;
  endproperty
  a_win_self: assert property (p_win_self) else $error("window self read not zero");

  property p_win_b;
    take && req.addr == `DMTRA_OFF_WIN_B && s_r.ptr_b >= `DMTRA_GP_BASE
    |-> tgt.ram == {s_r.bank_sel[2:0], s_r.ptr_b[6:0]};
  endproperty
  a_win_b: assert property (p_win_b) else $error("pointer_b bank wrong");

  property p_bank0;
    take && req.addr != `DMTRA_OFF_WIN_B |-> tgt.ram[9:7] == 3'h0;
  endproperty
  a_bank0: assert property (p_bank0) else $error("access left bank 0");

  property p_bset;
    take && req.op == dmtra_pkg::DMTRA_OP_BSET && tgt.kind == dmtra_pkg::DMTRA_TGT_RAM
    |=> ram_we && ram_wdata[s_r.pend_bit];
  endproperty
  a_bset: assert property (p_bset) else $error("bit set lost");

  property p_table_high_byte_load;
    s_r.st == dmtra_pkg::DMTRA_ST_WAIT && pm_rd |=> s_r.table_high_byte == $past(pm_rdata[15:8]);
  endproperty
  a_table_high_byte_load: assert property (p_table_high_byte_load) else $error("table_high_byte not loaded");

  c_tabrdl:  cover property (take && req.op == dmtra_pkg::DMTRA_OP_TABRDL ##2 done);
  c_win_b:   cover property (take && req.addr == `DMTRA_OFF_WIN_B && s_r.bank_sel[2:0] != 3'h0);
  c_bclr:    cover property (take && req.op == dmtra_pkg::DMTRA_OP_BCLR ##2 done);
endmodule // dmtra_top
`default_nettype wire

// [testbench/dmtra_pm_model.sv]
// dmtra_pm_model: program memory behind the table read port
// assumes: the word is wanted combinationally while pm_rd is high
`timescale 1ns/1ns
`default_nettype none
module dmtra_pm_model (
  input  wire logic        ref_clk,
  input  wire logic        pm_rd,
  input  wire logic [14:0] pm_addr,
  output logic      [15:0] pm_rdata
);
  logic [15:0] junk_r = 16'h1234;

  // outside a read the bus shows a pattern that moves every cycle
  always @(posedge ref_clk) begin
    junk_r <= ~junk_r ^ 16'h0101;
  end

  // stored word is a known function of its address
  assign pm_rdata = pm_rd ? {pm_addr[7:0] ^ 8'hc3, pm_addr[14:7]} : junk_r;
endmodule // dmtra_pm_model
`default_nettype wire

// [testbench/tb_top.sv]
// tb_top: self-checking bench for dmtra_top, large memory variant
// assumes: core files and dmtra_pm_model are compiled before this file
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                  ref_clk = 1'b0;
  logic                  rst = 1'b1;
  dmtra_pkg::dmtra_req_t req = '0;
  logic [6:0]            pc = 7'h00;
  logic [15:0]           pm_rdata;
  logic [14:0]           pm_addr;
  logic                  pm_rd;
  logic [7:0]            rd_data;
  logic                  rd_valid;
  logic                  busy;
  logic                  done;
  int                    n_errors = 0;
  int                    checks = 0;
  // shadow copy of data memory and registers
  logic [7:0]            ram [1024];
  logic [7:0]            pa = 8'h00;
  logic [7:0]            pb = 8'h00;
  logic [7:0]            bs = 8'h00;
  logic [7:0]            tp = 8'h00;
  logic [7:0]            th = 8'h00;
  logic [7:0]            regs [5] = '{8'h01, 8'h03, 8'h04, 8'h07, 8'h08};

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  dmtra_top #(.LARGE_MEM(1'b1)) dut (
    .ref_clk(ref_clk), .rst(rst), .req(req), .program_counter_upper_bits(pc),
    .pm_rdata(pm_rdata), .pm_addr(pm_addr), .pm_rd(pm_rd), .rd_data(rd_data),
    .rd_valid(rd_valid), .busy(busy), .done(done)
  );

  dmtra_pm_model pm (
    .ref_clk(ref_clk), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_rdata(pm_rdata)
  );

  // resolve an operand: bit 10 set means ram index, else register offset
  function automatic logic [10:0] res(input logic [7:0] a);
    logic [7:0] m;
    logic [2:0] b;
    m = a;
    b = 3'h0;
    if (a == 8'h00) m = pa;
    if (a == 8'h02) begin
      m = pb;
      b = bs[2:0];
    end
    return m[7] ? {1'b1, b, m[6:0]} : {3'h0, m};
  endfunction

  // expected read of a resolved place; unused places read zero
  function automatic logic [7:0] rdv(input logic [10:0] r);
    if (r[10]) return ram[r[9:0]];
    case (r[7:0])
      8'h01: return pa;
      8'h03: return pb;
      8'h04: return bs;
      8'h07: return tp;
      8'h08: return th;
      default: return 8'h00;
    endcase
  endfunction

  // shadow write; read-only and unused places keep nothing
  task automatic wrv(input logic [10:0] r, input logic [7:0] d);
    if (r[10]) ram[r[9:0]] = d;
    else case (r[7:0])
      8'h01: pa = d;
      8'h03: pb = d;
      8'h04: bs = d & 8'h67;
      8'h07: tp = d;
      default: ;
    endcase
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one request: present, let it be taken, wait for done and compare
  task automatic run(input logic [2:0] op, input logic [7:0] a, input logic [7:0] d,
                     input logic [2:0] bi);
    int          n;
    logic [10:0] r;
    logic [7:0]  e;
    logic [6:0]  p;
    logic [14:0] ea;
    r = res(a);
    e = rdv(r);
    p = 7'($urandom);
    ea = (op == 3'h5) ? {7'h7f, tp} : {bs[6:5], p[4:0], tp};
    @(posedge ref_clk);
    req <= '{1'b1, dmtra_pkg::dmtra_op_t'(op), a, d, bi};
    pc <= p;
    @(posedge ref_clk);
    req.valid <= 1'b0;
    for (n = 1; n < 5; n++) begin
      #1;
      check(16'(pm_rd), 16'((n == 1) && (op >= 3'h4)));
      check(16'(busy), 16'((n == 1) && (op != 3'h1)));
      if (op >= 3'h4 && n == 1) check(16'(pm_addr), 16'(ea));
      if (done === 1'b1) break;
      @(posedge ref_clk);
    end
    check(16'(n), (op == 3'h1) ? 16'h1 : 16'h2);
    check(16'(rd_valid), 16'(op == 3'h0));
    if (op == 3'h0) check(16'(rd_data), 16'(e));
    if (op == 3'h1) wrv(r, d);
    if (op == 3'h2 || op == 3'h3) begin
      e[bi] = (op == 3'h2);
      wrv(r, e);
    end
    if (op >= 3'h4) begin
      wrv(r, ea[14:7]);
      th = ea[7:0] ^ 8'hc3;
    end
  endtask

  // main sequence
  initial begin
    int         i;
    int         k;
    logic [7:0] a;
    void'($urandom(32'hdbb3));
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    for (k = 0; k < 5; k++) run(3'h0, regs[k], 8'h00, 3'h0);
    run(3'h1, 8'h04, 8'hff, 3'h0);
    run(3'h0, 8'h04, 8'h00, 3'h0);
    run(3'h1, 8'h08, 8'ha5, 3'h0);
    run(3'h2, 8'h08, 8'h00, 3'h3);
    run(3'h0, 8'h08, 8'h00, 3'h0);
    // fill every bank through pointer_b and window_b
    for (i = 0; i < 1024; i++) begin
      if (i[6:0] == 7'h00) run(3'h1, 8'h04, 8'(i >> 7), 3'h0);
      run(3'h1, 8'h03, {1'b1, i[6:0]}, 3'h0);
      run(3'h1, 8'h02, 8'($urandom), 3'h0);
    end
    // windows pointing at windows
    run(3'h1, 8'h01, 8'h02, 3'h0);
    run(3'h1, 8'h00, 8'h5a, 3'h0);
    run(3'h0, 8'h00, 8'h00, 3'h0);
    run(3'h1, 8'h03, 8'h00, 3'h0);
    run(3'h0, 8'h02, 8'h00, 3'h0);
    run(3'h1, 8'h07, 8'hff, 3'h0);
    run(3'h1, 8'h04, 8'h67, 3'h0);
    run(3'h4, 8'h80, 8'h00, 3'h0);
    run(3'h5, 8'hff, 8'h00, 3'h0);
    run(3'h0, 8'h08, 8'h00, 3'h0);
    // random mix of all operations
    for (i = 0; i < 700; i++) begin
      k = $urandom % 6;
      case ($urandom % 5)
        0: a = {1'b1, 7'($urandom)};
        1: a = 8'h00;
        2: a = 8'h02;
        3: a = regs[$urandom % 5];
        default: a = 8'($urandom) & 8'h7f;
      endcase
      if (k >= 4) a = (pb[7] && $urandom % 2) ? 8'h02 : {1'b1, 7'($urandom)};
      run(3'(k), a, 8'($urandom), 3'($urandom));
      if (k != 0) run(3'h0, a, 8'h00, 3'h0);
    end
    stop_test();
  end

  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
